/* emsc_pkg.sv */
// Shared constants and types of the external memory strobe control
package emsc_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SETUP_NS = 5;
  localparam int STROBE_NS = 20;
  localparam int HOLD_NS = 5;
  // Least times, rounded up to whole cycles
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 3;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 17;
  localparam int HI_SEL_W = 2;
  localparam int FIFO_DEPTH = 16;

  // Request word layout
  localparam int REQ_WDATA_LSB = 0;
  localparam int REQ_ADDR_LSB = 16;
  localparam int REQ_HI_SEL_LSB = 33;
  localparam int REQ_SEL_ZERO_BIT = 35;
  localparam int REQ_PROG_BIT = 36;
  localparam int REQ_WRITE_BIT = 37;
  localparam int REQ_W = 38;

  // Reset values
  localparam logic SEL_ZERO_PROG_RST = 1'b1;
  localparam logic STROBE_IDLE_RST = 1'b1;
  localparam logic OE_RST = 1'b0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_HOLD = 4'b1000
  } emsc_state_t;
endpackage

/* emsc_strobe_ctrl.sv */
// Request FIFO and strobe control of the external memory interface
//
// What this block does
// - Read strobe low during every external read, high otherwise.
// - While read strobe is low, the sixteen data pins are inputs.
// - Read data captured as the read strobe rises; memory holds it.
// - Active strobe qualifies address, program, data and chip selects.
// - Write strobe low during every external write, high otherwise.
// - While write strobe is low, data pins drive the write data.
// - Write data stays driven up to the write strobe rising edge.
// - Idle drive bit chooses tri-state or driven strobes when idle.
// - Software should set the idle drive bit to one; default is zero.
// - Strobe pull-up disable bit turns off read and write pull-ups.
// - After reset chip select zero acts as the program select.
// - Program select low for program accesses, high otherwise.
// - Program select pin also works as port D pin eight.
// - Port D pull-up bit eight clear turns off that pin's pull-up.
// - Data select low for data accesses, qualified like program select.
`timescale 1ns/1ps
`default_nettype none

module emsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_out = (count_reg != (PW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

module emsc_strobe_ctrl import emsc_pkg::*; (
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Access requests
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic req_write_in,
  input wire logic req_prog_in,
  input wire logic req_sel_zero_in,
  input wire logic [HI_SEL_W-1:0] req_hi_sel_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic rdata_valid_out,
  output logic busy_out,
  // Control bits
  input wire logic idle_bus_drive_in,
  input wire logic pullup_disable_in,
  input wire logic sel_zero_remap_in,
  input wire logic port_d_pin_eight_gpio_in,
  input wire logic port_d_pin_eight_dir_in,
  input wire logic port_d_pin_eight_data_in,
  input wire logic port_d_pullup_eight_in,
  output logic port_d_pin_eight_read_out,
  // External bus pins
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_out,
  input wire logic [DATA_W-1:0] data_pin_in,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic strobe_oe_out,
  output logic strobe_pullup_en_out,
  output logic program_select_n_out,
  output logic program_select_oe_out,
  input wire logic program_select_pin_in,
  output logic program_select_pullup_en_out,
  output logic data_select_n_out,
  output logic [HI_SEL_W-1:0] chip_selects_n_out
);
  function automatic logic [CNT_W-1:0] phase_len(input emsc_state_t st);
    logic [CNT_W-1:0] len;
    len = '0;
    unique case (st)
      ST_SETUP: len = CNT_W'(SETUP_CYC - 1);
      ST_STROBE: len = CNT_W'(STROBE_CYC - 1);
      ST_HOLD: len = CNT_W'(HOLD_CYC - 1);
      ST_IDLE: len = '0;
    endcase
    return len;
  endfunction

  logic q_valid;
  logic q_ready;
  logic [REQ_W-1:0] q_data;
  logic [REQ_W-1:0] op_reg;
  logic [REQ_W-1:0] op_next;
  emsc_state_t state_reg;
  emsc_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic out_en_reg;
  logic sel_zero_prog_reg;
  logic read_strobe_n_reg;
  logic write_strobe_n_reg;
  logic program_select_n_reg;
  logic data_select_n_reg;
  logic [HI_SEL_W-1:0] chip_selects_n_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic data_oe_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic rdata_valid_reg;
  logic pin_eight_read_reg;
  logic op_write;
  logic op_prog;
  logic sel_active;
  logic strobe_next;

  emsc_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_req_fifo (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .in_valid_in(req_valid_in),
    .in_ready_out(req_ready_out),
    .in_data_in({req_write_in, req_prog_in, req_sel_zero_in,
                 req_hi_sel_in, req_addr_in, req_wdata_in}),
    .out_valid_out(q_valid),
    .out_ready_in(q_ready),
    .out_data_out(q_data)
  );

  // A new request is only taken between accesses
  assign q_ready = (state_reg == ST_IDLE);
  assign op_next = (q_valid && q_ready) ? q_data : op_reg;
  assign op_write = op_next[REQ_WRITE_BIT];
  assign op_prog = op_next[REQ_PROG_BIT];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (q_valid) state_next = ST_SETUP;
      ST_SETUP: if (cnt_reg == '0) state_next = ST_STROBE;
      ST_STROBE: if (cnt_reg == '0) state_next = ST_HOLD;
      ST_HOLD: if (cnt_reg == '0) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  assign sel_active = (state_next != ST_IDLE);
  assign strobe_next = (state_next == ST_STROBE);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      op_reg <= '0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      if (state_next != state_reg) begin
        cnt_reg <= phase_len(state_next);
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Pins stay disabled during reset, as at power-up
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      out_en_reg <= OE_RST;
      sel_zero_prog_reg <= SEL_ZERO_PROG_RST;
      pin_eight_read_reg <= 1'b0;
    end else begin
      out_en_reg <= 1'b1;
      sel_zero_prog_reg <= !sel_zero_remap_in;
      pin_eight_read_reg <= program_select_pin_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      read_strobe_n_reg <= STROBE_IDLE_RST;
      write_strobe_n_reg <= STROBE_IDLE_RST;
    end else begin
      read_strobe_n_reg <= !(strobe_next && !op_write);
      write_strobe_n_reg <= !(strobe_next && op_write);
    end
  end

  // Selects and address span setup, strobe and hold, so they are
  // settled whenever a strobe is low
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      program_select_n_reg <= STROBE_IDLE_RST;
      data_select_n_reg <= STROBE_IDLE_RST;
      chip_selects_n_reg <= '1;
      addr_reg <= '0;
    end else begin
      if (sel_zero_prog_reg) begin
        program_select_n_reg <= !(sel_active && op_prog);
      end else begin
        program_select_n_reg <= !(sel_active && op_next[REQ_SEL_ZERO_BIT]);
      end
      data_select_n_reg <= !(sel_active && !op_prog);
      chip_selects_n_reg <= sel_active ?
        ~op_next[REQ_HI_SEL_LSB +: HI_SEL_W] : '1;
      if (q_valid && q_ready) begin
        addr_reg <= op_next[REQ_ADDR_LSB +: ADDR_W];
      end
    end
  end

  // Write data is driven from setup through hold, past the rising edge
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      data_oe_reg <= OE_RST;
      wdata_reg <= '0;
    end else begin
      data_oe_reg <= sel_active && op_write;
      wdata_reg <= op_next[REQ_WDATA_LSB +: DATA_W];
    end
  end

  // Read data is taken on the edge where the read strobe returns high
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdata_reg <= '0;
      rdata_valid_reg <= 1'b0;
    end else begin
      rdata_valid_reg <= 1'b0;
      if (state_reg == ST_STROBE && state_next == ST_HOLD && !op_write) begin
        rdata_reg <= data_pin_in;
        rdata_valid_reg <= 1'b1;
      end
    end
  end

  assign strobe_oe_out = out_en_reg &&
    (idle_bus_drive_in || state_reg != ST_IDLE);
  assign read_strobe_n_out = read_strobe_n_reg;
  assign write_strobe_n_out = write_strobe_n_reg;
  assign strobe_pullup_en_out = !pullup_disable_in;
  assign program_select_n_out = port_d_pin_eight_gpio_in ?
    port_d_pin_eight_data_in : program_select_n_reg;
  assign program_select_oe_out = out_en_reg && (port_d_pin_eight_gpio_in ?
    port_d_pin_eight_dir_in : strobe_oe_out);
  assign program_select_pullup_en_out = port_d_pullup_eight_in;
  assign port_d_pin_eight_read_out = pin_eight_read_reg;
  assign data_select_n_out = data_select_n_reg;
  assign chip_selects_n_out = chip_selects_n_reg;
  assign addr_out = addr_reg;
  assign data_out = wdata_reg;
  assign data_oe_out = data_oe_reg;
  assign rdata_out = rdata_reg;
  assign rdata_valid_out = rdata_valid_reg;
  assign busy_out = (state_reg != ST_IDLE);

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  property p_read_strobe;
    !read_strobe_n_reg |-> state_reg == ST_STROBE && !op_reg[REQ_WRITE_BIT];
  endproperty
  a_read_strobe: assert property (p_read_strobe)
    else $error("read strobe low outside a read");
  property p_read_release;
    !read_strobe_n_reg |-> !data_oe_reg;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("data bus driven during read strobe");
  property p_read_capture;
    $rose(read_strobe_n_reg) |->
      rdata_valid_reg && rdata_reg == $past(data_pin_in);
  endproperty
  a_read_capture: assert property (p_read_capture)
    else $error("read data not captured at strobe rise");
  property p_qualify;
    (!read_strobe_n_reg || !write_strobe_n_reg) ##1
      (!read_strobe_n_reg || !write_strobe_n_reg) |->
      $stable(addr_reg) && $stable(data_select_n_reg) &&
      $stable(program_select_n_reg) && $stable(chip_selects_n_reg);
  endproperty
  a_qualify: assert property (p_qualify)
    else $error("address or select changed under a strobe");
  property p_write_strobe;
    $fell(write_strobe_n_reg) |->
      !write_strobe_n_reg [*4] ##1 write_strobe_n_reg;
  endproperty
  a_write_strobe: assert property (p_write_strobe)
    else $error("write strobe width wrong");
  property p_write_drive;
    !write_strobe_n_reg |-> data_oe_reg && op_reg[REQ_WRITE_BIT] &&
      data_out == op_reg[REQ_WDATA_LSB +: DATA_W];
  endproperty
  a_write_drive: assert property (p_write_drive)
    else $error("write data not driven under write strobe");
  property p_write_hold;
    $rose(write_strobe_n_reg) |-> data_oe_reg && $stable(wdata_reg);
  endproperty
  a_write_hold: assert property (p_write_hold)
    else $error("write data dropped before strobe rise");
  property p_idle_tristate;
    state_reg == ST_IDLE && !idle_bus_drive_in |-> !strobe_oe_out;
  endproperty
  a_idle_tristate: assert property (p_idle_tristate)
    else $error("strobes driven on idle bus with drive bit clear");
  property p_sel_zero_reset;
    $fell(rst_in) |-> sel_zero_prog_reg;
  endproperty
  a_sel_zero_reset: assert property (
    @(posedge core_clk_in) p_sel_zero_reset)
    else $error("chip select zero not program select after reset");
  property p_program_select;
    !program_select_n_reg && sel_zero_prog_reg |->
      op_reg[REQ_PROG_BIT] && data_select_n_reg;
  endproperty
  a_program_select: assert property (p_program_select)
    else $error("program select low on a data access");
  property p_exclusive;
    !(!read_strobe_n_reg && !write_strobe_n_reg);
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("read and write strobes both low");
  c_read: cover property ($rose(read_strobe_n_reg) && rdata_valid_reg);
  c_write: cover property ($rose(write_strobe_n_reg));
  c_fifo_full: cover property (!req_ready_out);
  c_back_to_back: cover property ($rose(write_strobe_n_reg) ##[1:6]
    $fell(read_strobe_n_reg));
endmodule

`default_nettype wire

/* emsc_sram_model.sv */
// Behavioural external static memory on the strobe bus
`timescale 1ns/1ps
`default_nettype none
module emsc_sram_model (
  input wire logic core_clk_in,
  input wire logic slow_in,
  input wire logic [16:0] addr_in,
  input wire logic [15:0] data_in,
  input wire logic data_oe_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic program_select_n_in,
  input wire logic data_select_n_in,
  output logic [15:0] data_pin_out
);
  logic [15:0] mem_reg [32];
  logic [15:0] last_reg = 16'h0000;
  logic [2:0] low_cnt_reg = 3'h0;
  logic sel;
  logic [4:0] idx;
  assign sel = !program_select_n_in || !data_select_n_in;
  assign idx = {!program_select_n_in, addr_in[3:0]};
  // Slow part shows data only from the third strobe cycle
  always_comb begin
    if (data_oe_in) begin
      data_pin_out = data_in;
    end else if (!read_strobe_n_in && sel &&
                 (!slow_in || low_cnt_reg >= 3'h2)) begin
      data_pin_out = mem_reg[idx];
    end else begin
      data_pin_out = ~last_reg;
    end
  end
  always @(posedge core_clk_in) begin
    last_reg <= data_pin_out;
    low_cnt_reg <= read_strobe_n_in ? 3'h0 : low_cnt_reg + 3'h1;
  end
  // Latch on the rising write strobe whatever the pins show
  always @(posedge write_strobe_n_in) begin
    if (sel) begin
      mem_reg[idx] = data_pin_out;
    end
  end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench of the external memory strobe control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import emsc_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid_in = 1'b0, req_write_in = 1'b0, req_prog_in = 1'b0;
  logic req_sel_zero_in = 1'b0, slow = 1'b0;
  logic [1:0] req_hi_sel_in = 2'h0;
  logic [16:0] req_addr_in = 17'h00000;
  logic [15:0] req_wdata_in = 16'h0000, rdata_out, data_out, data_pin_in;
  logic idle_bus_drive_in = 1'b0, pullup_disable_in = 1'b0;
  logic sel_zero_remap_in = 1'b0, port_d_pin_eight_gpio_in = 1'b0;
  logic port_d_pin_eight_dir_in = 1'b0, port_d_pin_eight_data_in = 1'b0;
  logic port_d_pullup_eight_in = 1'b1, program_select_pin_in;
  logic req_ready_out, rdata_valid_out, busy_out, port_d_pin_eight_read_out;
  logic data_oe_out, read_strobe_n_out, write_strobe_n_out, strobe_oe_out;
  logic strobe_pullup_en_out, program_select_n_out, program_select_oe_out;
  logic program_select_pullup_en_out, data_select_n_out;
  logic [1:0] chip_selects_n_out;
  logic [16:0] addr_out;
  int err_count = 0, cmp_count = 0, cyc = 0;
  logic [15:0] rv;

  always #2.5 core_clk_in = ~core_clk_in;

  emsc_strobe_ctrl u_dut (.core_clk_in, .rst_in, .req_valid_in,
    .req_ready_out, .req_write_in, .req_prog_in, .req_sel_zero_in,
    .req_hi_sel_in, .req_addr_in, .req_wdata_in, .rdata_out,
    .rdata_valid_out, .busy_out, .idle_bus_drive_in, .pullup_disable_in,
    .sel_zero_remap_in, .port_d_pin_eight_gpio_in, .port_d_pin_eight_dir_in,
    .port_d_pin_eight_data_in, .port_d_pullup_eight_in,
    .port_d_pin_eight_read_out, .addr_out, .data_out, .data_oe_out,
    .data_pin_in, .read_strobe_n_out, .write_strobe_n_out, .strobe_oe_out,
    .strobe_pullup_en_out, .program_select_n_out, .program_select_oe_out,
    .program_select_pin_in, .program_select_pullup_en_out,
    .data_select_n_out, .chip_selects_n_out);

  emsc_sram_model u_mem (.core_clk_in, .slow_in(slow), .addr_in(addr_out),
    .data_in(data_out), .data_oe_in(data_oe_out),
    .read_strobe_n_in(read_strobe_n_out),
    .write_strobe_n_in(write_strobe_n_out),
    .program_select_n_in(program_select_n_out),
    .data_select_n_in(data_select_n_out), .data_pin_out(data_pin_in));

  // Released pin floats high with pull-up, otherwise wanders
  assign program_select_pin_in = program_select_oe_out ?
    program_select_n_out : (program_select_pullup_en_out | cyc[0]);

  task automatic check(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  always @(negedge core_clk_in) begin
    if (!read_strobe_n_out && !write_strobe_n_out) begin
      check("both strobes", 1, 0);
    end
  end

  task automatic send(input logic w, p, s0, input logic [16:0] a,
                      input logic [15:0] d);
    logic rdy;
    @(posedge core_clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= w;
    req_prog_in <= p;
    req_sel_zero_in <= s0;
    req_addr_in <= a;
    req_wdata_in <= d;
    rdy = 1'b0;
    while (!rdy) begin
      @(negedge core_clk_in);
      rdy = req_ready_out;
      @(posedge core_clk_in);
    end
    req_valid_in <= 1'b0;
  endtask

  // One access, judged cycle by cycle while a strobe is low
  task automatic access(input logic w, p, s0, input logic [16:0] a,
    input logic [15:0] d, input logic eps, eds, output logic [15:0] rd);
    int low;
    logic [1:0] kind;
    low = 0;
    rd = 'x;
    send(w, p, s0, a, d);
    repeat (12) begin
      @(posedge core_clk_in);
      #1;
      if (!read_strobe_n_out || !write_strobe_n_out) begin
        low++;
        kind = {read_strobe_n_out, write_strobe_n_out};
        check("strobe kind", kind, {w, !w});
        check("chip sel", chip_selects_n_out, 2'(~req_hi_sel_in));
        check("prog oe", program_select_oe_out, 1);
        check("data dir", data_oe_out, w);
        check("prog sel", program_select_n_out, eps);
        check("data sel", data_select_n_out, eds);
        check("addr", addr_out, a);
        check("strobe oe", strobe_oe_out, 1);
        if (w) check("wdata", data_out, d);
      end
      if (rdata_valid_out) rd = rdata_out;
    end
    check("strobe len", low, STROBE_CYC);
  endtask

  task automatic t_reset();
    check("idle oe", strobe_oe_out, 0);
    check("strobes", {read_strobe_n_out, write_strobe_n_out}, 2'h3);
    check("prog sel idle", program_select_n_out, 1);
    check("data oe idle", data_oe_out, 0);
    check("ready", req_ready_out, 1);
    check("cs idle", chip_selects_n_out, 2'h3);
  endtask

  task automatic t_mem();
    access(1, 0, 0, 17'h00003, 16'ha5c3, 1, 0, rv);
    @(posedge core_clk_in);
    req_hi_sel_in <= 2'h1;
    access(1, 1, 0, 17'h00003, 16'h3c5a, 0, 1, rv);
    slow = 1'b1;
    @(posedge core_clk_in);
    req_hi_sel_in <= 2'h2;
    access(0, 0, 0, 17'h00003, 16'h0000, 1, 0, rv);
    check("data rd", rv, 16'ha5c3);
    slow = 1'b0;
    access(0, 1, 0, 17'h00003, 16'h0000, 0, 1, rv);
    check("prog rd", rv, 16'h3c5a);
    @(posedge core_clk_in);
    req_hi_sel_in <= 2'h0;
    sel_zero_remap_in <= 1'b1;
    access(0, 0, 1, 17'h00003, 16'h0000, 0, 0, rv);
    check("remap rd", rv, 16'h3c5a);
    @(posedge core_clk_in);
    sel_zero_remap_in <= 1'b0;
  endtask

  task automatic t_pins();
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_in);
      idle_bus_drive_in <= i[0];
      pullup_disable_in <= i[0];
      port_d_pullup_eight_in <= i[0];
      port_d_pin_eight_gpio_in <= 1'b1;
      port_d_pin_eight_dir_in <= 1'b1;
      port_d_pin_eight_data_in <= i[0];
      repeat (2) @(posedge core_clk_in);
      #1;
      check("idle drive", strobe_oe_out, i[0]);
      check("strobe pu", strobe_pullup_en_out, !i[0]);
      check("pin pu", program_select_pullup_en_out, i[0]);
      check("gpio out", program_select_n_out, i[0]);
      check("gpio oe", program_select_oe_out, 1);
      check("gpio in", port_d_pin_eight_read_out, i[0]);
    end
    @(posedge core_clk_in);
    port_d_pin_eight_dir_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1;
    check("gpio rel", port_d_pin_eight_read_out, 1);
    check("gpio off", program_select_oe_out, 0);
    @(posedge core_clk_in);
    port_d_pin_eight_gpio_in <= 1'b0;
  endtask

  task automatic t_fill();
    int n, idle;
    logic rdy;
    n = 0;
    rdy = 1'b1;
    @(posedge core_clk_in);
    while (rdy && n < 40) begin
      req_valid_in <= 1'b1;
      req_write_in <= 1'b1;
      req_prog_in <= 1'b0;
      req_addr_in <= 17'(n % 16);
      req_wdata_in <= 16'h1000 + 16'(n);
      @(negedge core_clk_in);
      rdy = req_ready_out;
      @(posedge core_clk_in);
      if (rdy) n++;
    end
    check("refused", rdy, 0);
    // A refused request stays offered until the FIFO takes it
    while (!rdy) begin
      @(negedge core_clk_in);
      rdy = req_ready_out;
      @(posedge core_clk_in);
    end
    if (n < 40) n++;
    req_valid_in <= 1'b0;
    check("depth", n >= FIFO_DEPTH, 1);
    idle = 0;
    for (int k = 0; k < 400 && idle < 3; k++) begin
      @(posedge core_clk_in);
      #1;
      idle = busy_out ? 0 : idle + 1;
    end
    check("drained", idle, 3);
    access(0, 0, 0, 17'((n - 1) % 16), 16'h0000, 1, 0, rv);
    check("fill rd", rv, 16'h1000 + 16'(n - 1));
  endtask

  initial begin
    repeat (4) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
    t_reset();
    t_mem();
    t_pins();
    t_fill();
    end_sim();
  end
endmodule
`default_nettype wire
